// *** tb/ieb_bank_asserts.sv ***
// Port-level checks for the interrupt enable bank
module ieb_bank_asserts
   import ieb_pkg::*;
#(
   parameter int ADDR_W = 13
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   input wire logic [1:0] avs_response_o,
   input wire ieb_pkg::ieb_byte_t flag1_i, flag2_i, flag3_i, flag4_i,
   input wire ieb_pkg::ieb_byte_t flag5_i, flag6_i, flag7_i,
   input wire ieb_pkg::ieb_byte_t req1_o, req2_o, req3_o, req4_o,
   input wire ieb_pkg::ieb_byte_t req5_o, req6_o, req7_o,
   input wire logic req_any_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   logic [10:0] idx;
   logic mapped;
   logic req_on;
   logic [55:0] reqs;
   logic [55:0] flags;
   assign idx = avs_address_i[12:2];
   assign mapped = avs_address_i[1:0] == 2'h0 && idx >= 11'h4a9
      && idx <= 11'h4af;
   assign req_on = avs_read_i || avs_write_i;
   assign reqs = {req7_o, req6_o, req5_o, req4_o, req3_o, req2_o, req1_o};
   assign flags = {flag7_i, flag6_i, flag5_i, flag4_i, flag3_i, flag2_i,
      flag1_i};
   property p_one_wait;
      req_on && avs_waitrequest_o |=> !avs_waitrequest_o;
   endproperty
   a_one_wait: assert property (p_one_wait) else $error("no answer");
   property p_answer_one;
      $fell(avs_waitrequest_o) |=> avs_waitrequest_o;
   endproperty
   a_answer_one: assert property (p_answer_one) else $error("long answer");
   property p_no_spurious;
      !avs_waitrequest_o |-> $past(req_on);
   endproperty
   a_no_spurious: assert property (p_no_spurious) else $error("spurious");
   property p_resp;
      !avs_waitrequest_o |-> avs_response_o == (mapped ? 2'h0 : 2'h2);
   endproperty
   a_resp: assert property (p_resp) else $error("bad response");
   property p_err_zero;
      !avs_waitrequest_o && avs_read_i && !mapped |-> avs_readdata_o == 0;
   endproperty
   a_err_zero: assert property (p_err_zero) else $error("unmapped data");
   property p_rd_hi;
      !avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h0;
   endproperty
   a_rd_hi: assert property (p_rd_hi) else $error("upper data set");
   property p_absent;
      (reqs & ~56'hef_fd_f7_ff_ff_f1_07) == 56'h0;
   endproperty
   a_absent: assert property (p_absent) else $error("absent bit");
   property p_gate;
      1'b1 |=> (reqs & ~$past(flags)) == 56'h0;
   endproperty
   a_gate: assert property (p_gate) else $error("request w/o flag");
   property p_any;
      req_any_o == (|reqs);
   endproperty
   a_any: assert property (p_any) else $error("summary mismatch");
   property p_rst;
      $fell(rst_i) |-> avs_waitrequest_o && !req_any_o && reqs == 56'h0;
   endproperty
   a_rst: assert property (p_rst) else $error("reset state");
   c_write: cover property (avs_write_i && !avs_waitrequest_o);
   c_err: cover property (!avs_waitrequest_o && avs_response_o == 2'h2);
   c_any: cover property ($rose(req_any_o));
endmodule

bind ieb_bank ieb_bank_asserts #(.ADDR_W(ADDR_W)) ieb_bank_asserts_i (
   .clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
   .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
   .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
   .avs_response_o(avs_response_o), .flag1_i(flag1_i), .flag2_i(flag2_i),
   .flag3_i(flag3_i), .flag4_i(flag4_i), .flag5_i(flag5_i),
   .flag6_i(flag6_i), .flag7_i(flag7_i), .req1_o(req1_o), .req2_o(req2_o),
   .req3_o(req3_o), .req4_o(req4_o), .req5_o(req5_o), .req6_o(req6_o),
   .req7_o(req7_o), .req_any_o(req_any_o));

// *** tb/ieb_bank_test.sv ***
// Self-checking bench for the interrupt enable bank
module ieb_bank_test;
   timeunit 1ns;
   timeprecision 1ns;
   import ieb_pkg::*;
   localparam logic [55:0] MSK = 56'hef_fd_f7_ff_ff_f1_07;
   localparam logic [55:0] PAT = {7{8'h5a}};
   logic clk_i, rst_i, avs_read_i, avs_write_i, avs_waitrequest_o, req_any_o;
   logic [12:0] avs_address_i;
   logic [31:0] avs_writedata_i, avs_readdata_o;
   logic [3:0] avs_byteenable_i;
   logic [1:0] avs_response_o;
   logic [55:0] flg;
   wire logic [55:0] req;
   int num_errors, check_count;

   ieb_bank #(.ADDR_W(13)) ieb_bank_i (
      .clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
      .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
      .avs_response_o(avs_response_o), .flag1_i(flg[7:0]),
      .flag2_i(flg[15:8]), .flag3_i(flg[23:16]), .flag4_i(flg[31:24]),
      .flag5_i(flg[39:32]), .flag6_i(flg[47:40]), .flag7_i(flg[55:48]),
      .req1_o(req[7:0]), .req2_o(req[15:8]), .req3_o(req[23:16]),
      .req4_o(req[31:24]), .req5_o(req[39:32]), .req6_o(req[47:40]),
      .req7_o(req[55:48]), .req_any_o(req_any_o));

   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end

   function automatic logic [12:0] adr(input int i);
      return 13'h12a0 + 13'(i * 4);
   endfunction

   task automatic print_verdict();
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic fail(input string m);
      num_errors++;
      $display("unexpected at %0t: %s", $time, m);
   endtask

   task automatic chk(input logic [63:0] g, input logic [63:0] e,
         input string m);
      check_count++;
      if (g !== e)
         fail($sformatf("%s got %h exp %h", m, g, e));
   endtask

   // Entered and left just after a rising edge; waitrequest and read data
   // are read in the edge's own time step, before the registers move
   task automatic bus(input logic wr, input logic [12:0] a,
         input logic [7:0] d, input logic [3:0] be,
         output logic [31:0] q, output logic [1:0] r);
      int n;
      n = 0;
      avs_address_i <= a;
      avs_writedata_i <= {24'h0, d};
      avs_byteenable_i <= be;
      avs_read_i <= !wr;
      avs_write_i <= wr;
      do begin
         @(posedge clk_i);
         n++;
      end while (avs_waitrequest_o !== 1'b0 && n < 20);
      if (avs_waitrequest_o !== 1'b0) begin
         fail("bus timeout");
         print_verdict();
      end
      q = avs_readdata_o;
      r = avs_response_o;
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
      // One idle edge so the next call never re-raises in this time step
      @(posedge clk_i);
   endtask

   task automatic rd(input logic [12:0] a, input logic [7:0] e,
         input logic [1:0] re);
      logic [31:0] q;
      logic [1:0] r;
      bus(1'b0, a, 8'h00, 4'hf, q, r);
      chk(64'(q), 64'(e), "readdata");
      chk(64'(r), 64'(re), "response");
   endtask

   task automatic wr(input logic [12:0] a, input logic [7:0] d,
         input logic [3:0] be);
      logic [31:0] q;
      logic [1:0] r;
      bus(1'b1, a, d, be, q, r);
   endtask

   task automatic chk_req(input logic [55:0] e, input logic a);
      @(posedge clk_i);
      @(negedge clk_i);
      chk(64'(req), 64'(e), "requests");
      chk(64'(req_any_o), 64'(a), "summary");
      @(posedge clk_i);
   endtask

   task automatic do_reset();
      rst_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic t_reset_vals();
      for (int i = 1; i <= 7; i++)
         rd(adr(i), 8'h00, 2'h0);
   endtask

   // Ones then a pattern, so neither a stuck bit nor a lost bit hides
   task automatic t_rw();
      for (int i = 1; i <= 7; i++) begin
         wr(adr(i), 8'hff, 4'h1);
         rd(adr(i), MSK[8*(i-1)+:8], 2'h0);
         wr(adr(i), 8'h5a, 4'h1);
         rd(adr(i), PAT[7:0] & MSK[8*(i-1)+:8], 2'h0);
      end
   endtask

   task automatic t_map();
      rd(13'h12a0, 8'h00, 2'h2);
      rd(13'h12c0, 8'h00, 2'h2);
      rd(13'h12a9, 8'h00, 2'h2);
      wr(13'h12c0, 8'hff, 4'h1);
      rd(adr(7), 8'h4a, 2'h0);
      wr(adr(2), 8'hff, 4'h0);
      rd(adr(2), 8'h50, 2'h0);
   endtask

   task automatic t_req();
      flg <= {7{8'ha5}};
      chk_req(56'h0, 1'b0);
      flg <= '1;
      chk_req(MSK & PAT, 1'b1);
      wr(adr(3), 8'h00, 4'h1);
      chk_req(MSK & PAT & ~(56'hff << 16), 1'b1);
      wr(adr(1), 8'hff, 4'h1);
      chk_req((MSK & PAT & ~(56'hff << 16)) | 56'h07, 1'b1);
      // All enables on, then the other half of the bits as flags
      for (int i = 1; i <= 7; i++)
         wr(adr(i), 8'hff, 4'h1);
      chk_req(MSK, 1'b1);
      flg <= {7{8'ha5}};
      chk_req(MSK & {7{8'ha5}}, 1'b1);
   endtask

   // Second reset with flags still raised must drop every request
   task automatic t_midreset();
      do_reset();
      chk_req(56'h0, 1'b0);
      t_reset_vals();
   endtask

   initial begin
      rst_i = 1'b1;
      avs_read_i = 1'b0;
      avs_write_i = 1'b0;
      avs_address_i = '0;
      avs_writedata_i = '0;
      avs_byteenable_i = '0;
      flg = '0;
      num_errors = 0;
      check_count = 0;
      do_reset();
      t_reset_vals();
      t_rw();
      t_map();
      t_req();
      t_midreset();
      print_verdict();
   end
endmodule

// *** verilog/ieb_bank.sv ***
// Peripheral interrupt enable bank with an Avalon-MM register slave
//
// How it works
// RL1 - Register one bit 2 enables the ADC conversion request.
// RL2 - Register one bit 1 enables the zero-cross detector request.
// RL3 - Register one bit 0 enables external pin 0 request.
// RL4 - Register two bits 7..4: DMA channel 1 abort, overrun, dest, source.
// RL5 - Register two bit 0 enables ADC threshold; bits 3..1 absent.
// RL6 - Register three: timer0 bit 7, timer1 gate 5, timer1 4, timer2 3.
// RL7 - Register three bit 6 enables capture/compare unit 1 request.
// RL8 - Register three: SPI port 1 general 2, transmit 1, receive 0.
// RL9 - Register four: PWM unit 1 parameter bit 7, period bit 6.
// RL10 - Register four: timer 3 gate bit 5, timer 3 overflow bit 4.
// RL11 - Register four: UART1 general 3, framing 2, transmit 1, receive 0.
// RL12 - Register five: PWM unit 2 parameter bit 7, period bit 6.
// RL13 - Register five: logic cell 2 bit 5, comparator 2 bit 4; 3 absent.
// RL14 - Register five: SPI port 2 general 2, transmit 1, receive 0.
// RL15 - Register six bits 7..4: DMA channel 2 abort, overrun, dest, source.
// RL16 - Register six: oscillator 3, waveform 2, pin 1 at 0; bit 1 absent.
// RL17 - Register seven: PWM3 parameter 7, period 6, cell 3 at 5; 4 absent.
// RL18 - Register seven: I2C1 error 3, general 2, transmit 1, receive 0.
// RL19 - Implemented enable bits are read/write and clear on reset.
// RL20 - Registers two to seven sit at consecutive indices 4aa..4af.
// RL21 - A request passes only while its flag and enable are both set.
// RL22 - Absent bit positions ignore writes and read back zero.
//
// Local design decision: the Avalon-MM register port.
`include "ieb_cfg.svh"

module ieb_bank #(
   parameter int ADDR_W = 13
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   output logic [1:0] avs_response_o,
   input wire ieb_pkg::ieb_byte_t flag1_i,
   input wire ieb_pkg::ieb_byte_t flag2_i,
   input wire ieb_pkg::ieb_byte_t flag3_i,
   input wire ieb_pkg::ieb_byte_t flag4_i,
   input wire ieb_pkg::ieb_byte_t flag5_i,
   input wire ieb_pkg::ieb_byte_t flag6_i,
   input wire ieb_pkg::ieb_byte_t flag7_i,
   output ieb_pkg::ieb_byte_t req1_o,
   output ieb_pkg::ieb_byte_t req2_o,
   output ieb_pkg::ieb_byte_t req3_o,
   output ieb_pkg::ieb_byte_t req4_o,
   output ieb_pkg::ieb_byte_t req5_o,
   output ieb_pkg::ieb_byte_t req6_o,
   output ieb_pkg::ieb_byte_t req7_o,
   output logic req_any_o
);
   import ieb_pkg::*;

   localparam ieb_byte_t IMPL_C [1:7] = '{
      `IEB_IMPL_R1,
      `IEB_IMPL_R2,
      `IEB_IMPL_R3,
      `IEB_IMPL_R4,
      `IEB_IMPL_R5,
      `IEB_IMPL_R6,
      `IEB_IMPL_R7
   };

   ieb_byte_t mask_ff [1:7];
   ieb_byte_t req_ff [1:7];
   ieb_byte_t gate_a [1:7];
   ieb_byte_t flag_a [1:7];
   ieb_bus_st_t state_ff;
   ieb_bus_st_t nxt_state;
   logic [31:0] rdata_ff;
   logic [1:0] resp_ff;
   logic [ADDR_W-3:0] idx;
   logic hit;
   logic [2:0] sel;
   logic req_on;
   logic wr_fire;
   ieb_byte_t rd_byte;

   // Named enables, register one
   logic adc_done_irq_en;
   logic zero_cross_irq_en;
   logic ext_pin0_irq_en;

   // Register two
   logic dma_ch1_abort_en;
   logic dma_ch1_overrun_en;
   logic dma_ch1_dest_count_en;
   logic dma_ch1_src_count_en;
   logic adc_threshold_irq_en;

   // Register three
   logic timer_zero_irq_en;
   logic capcomp_unit1_irq_en;
   logic timer_one_gate_irq_en;
   logic timer_one_irq_en;
   logic timer_two_irq_en;
   logic spi_port1_irq_en;
   logic spi_port1_tx_en;
   logic spi_port1_rx_en;

   // Register four
   logic pwm_unit1_param_en;
   logic pwm_unit1_period_en;
   logic timer_three_gate_irq_en;
   logic timer_three_irq_en;
   logic uart_port1_irq_en;
   logic uart_port1_framing_en;
   logic uart_port1_tx_en;
   logic uart_port1_rx_en;

   // Register five
   logic pwm_unit2_param_en;
   logic pwm_unit2_period_en;
   logic logic_cell2_irq_en;
   logic comparator2_irq_en;
   logic spi_port2_irq_en;
   logic spi_port2_tx_en;
   logic spi_port2_rx_en;

   // Register six
   logic dma_ch2_abort_en;
   logic dma_ch2_overrun_en;
   logic dma_ch2_dest_count_en;
   logic dma_ch2_src_count_en;
   logic osc_generator_irq_en;
   logic waveform_gen_irq_en;
   logic ext_pin1_irq_en;

   // Register seven
   logic pwm_unit3_param_en;
   logic pwm_unit3_period_en;
   logic logic_cell3_irq_en;
   logic i2c_port1_error_en;
   logic i2c_port1_irq_en;
   logic i2c_port1_tx_en;
   logic i2c_port1_rx_en;

   // Address decode; misaligned addresses count as unmapped
   assign idx = avs_address_i[ADDR_W-1:2];
   assign hit = (idx >= `IEB_IDX_R1) && (idx <= `IEB_IDX_R7)
      && (avs_address_i[1:0] == 2'h0); // RL20
   assign sel = 3'(idx - `IEB_IDX_BASE); // RL20
   assign req_on = avs_read_i | avs_write_i;
   assign wr_fire = avs_write_i && (state_ff == IEB_ST_ANS) && hit
      && avs_byteenable_i[0];

   // One wait cycle for every access keeps read data registered
   assign avs_waitrequest_o = (state_ff != IEB_ST_ANS);
   assign avs_readdata_o = rdata_ff;
   assign avs_response_o = resp_ff;

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         IEB_ST_IDLE: begin
            if (req_on) begin
               nxt_state = IEB_ST_ANS;
            end
         end
         IEB_ST_ANS: begin
            nxt_state = IEB_ST_IDLE;
         end
         default: begin
            nxt_state = IEB_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_ff <= IEB_ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   always_comb begin
      rd_byte = 8'h00;
      if (hit) begin
         rd_byte = mask_ff[sel] & IMPL_C[sel]; // RL22
      end
   end

   // Read data and answer are captured while waitrequest is high
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_ff <= 32'h0000_0000;
         resp_ff <= `IEB_RESP_OK;
      end else if (state_ff == IEB_ST_IDLE && req_on) begin
         rdata_ff <= avs_read_i ? {24'h00_0000, rd_byte} : 32'h0000_0000;
         resp_ff <= hit ? `IEB_RESP_OK : `IEB_RESP_ERR;
      end
   end

   // Enable storage; the write lands at the edge waitrequest is low
   generate
      for (genvar r = 1; r <= 7; r++) begin : g_reg
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               mask_ff[r] <= `IEB_RST_VAL; // RL19
            end else if (wr_fire && sel == 3'(r)) begin
               mask_ff[r] <= avs_writedata_i[7:0] & IMPL_C[r]; // RL19 RL22
            end
         end

         // Registered gate so requests never glitch downstream
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               req_ff[r] <= 8'h00;
            end else begin
               req_ff[r] <= flag_a[r] & gate_a[r]; // RL21
            end
         end
      end
   endgenerate

   assign flag_a[1] = flag1_i;
   assign flag_a[2] = flag2_i;
   assign flag_a[3] = flag3_i;
   assign flag_a[4] = flag4_i;
   assign flag_a[5] = flag5_i;
   assign flag_a[6] = flag6_i;
   assign flag_a[7] = flag7_i;

   assign req1_o = req_ff[1];
   assign req2_o = req_ff[2];
   assign req3_o = req_ff[3];
   assign req4_o = req_ff[4];
   assign req5_o = req_ff[5];
   assign req6_o = req_ff[6];
   assign req7_o = req_ff[7];
   assign req_any_o = |{req_ff[1], req_ff[2], req_ff[3], req_ff[4],
      req_ff[5], req_ff[6], req_ff[7]};

   // Register one: only the low three bits live in this bank
   assign adc_done_irq_en = mask_ff[1][`IEB_B_ADC_DONE]; // RL1
   assign zero_cross_irq_en = mask_ff[1][`IEB_B_ZERO_CROSS]; // RL2
   assign ext_pin0_irq_en = mask_ff[1][`IEB_B_EXT_PIN0]; // RL3

   // Register two
   assign dma_ch1_abort_en = mask_ff[2][`IEB_B_DMA_ABORT]; // RL4
   assign dma_ch1_overrun_en = mask_ff[2][`IEB_B_DMA_OVERRUN]; // RL4
   assign dma_ch1_dest_count_en = mask_ff[2][`IEB_B_DMA_DEST]; // RL4
   assign dma_ch1_src_count_en = mask_ff[2][`IEB_B_DMA_SRC]; // RL4
   assign adc_threshold_irq_en = mask_ff[2][`IEB_B_ADC_THRESH]; // RL5

   // Register three
   assign timer_zero_irq_en = mask_ff[3][`IEB_B_TMR0]; // RL6
   assign capcomp_unit1_irq_en = mask_ff[3][`IEB_B_CAPCOMP1]; // RL7
   assign timer_one_gate_irq_en = mask_ff[3][`IEB_B_TMR1_GATE]; // RL6
   assign timer_one_irq_en = mask_ff[3][`IEB_B_TMR1]; // RL6
   assign timer_two_irq_en = mask_ff[3][`IEB_B_TMR2]; // RL6
   assign spi_port1_irq_en = mask_ff[3][`IEB_B_SER_GEN]; // RL8
   assign spi_port1_tx_en = mask_ff[3][`IEB_B_SER_TX]; // RL8
   assign spi_port1_rx_en = mask_ff[3][`IEB_B_SER_RX]; // RL8

   // Register four
   assign pwm_unit1_param_en = mask_ff[4][`IEB_B_PWM_PARAM]; // RL9
   assign pwm_unit1_period_en = mask_ff[4][`IEB_B_PWM_PERIOD]; // RL9
   assign timer_three_gate_irq_en = mask_ff[4][`IEB_B_TMR3_GATE]; // RL10
   assign timer_three_irq_en = mask_ff[4][`IEB_B_TMR3]; // RL10
   assign uart_port1_irq_en = mask_ff[4][`IEB_B_UART_GEN]; // RL11
   assign uart_port1_framing_en = mask_ff[4][`IEB_B_UART_FRAME]; // RL11
   assign uart_port1_tx_en = mask_ff[4][`IEB_B_SER_TX]; // RL11
   assign uart_port1_rx_en = mask_ff[4][`IEB_B_SER_RX]; // RL11

   // Register five
   assign pwm_unit2_param_en = mask_ff[5][`IEB_B_PWM_PARAM]; // RL12
   assign pwm_unit2_period_en = mask_ff[5][`IEB_B_PWM_PERIOD]; // RL12
   assign logic_cell2_irq_en = mask_ff[5][`IEB_B_CELL2]; // RL13
   assign comparator2_irq_en = mask_ff[5][`IEB_B_CMP2]; // RL13
   assign spi_port2_irq_en = mask_ff[5][`IEB_B_SER_GEN]; // RL14
   assign spi_port2_tx_en = mask_ff[5][`IEB_B_SER_TX]; // RL14
   assign spi_port2_rx_en = mask_ff[5][`IEB_B_SER_RX]; // RL14

   // Register six
   assign dma_ch2_abort_en = mask_ff[6][`IEB_B_DMA_ABORT]; // RL15
   assign dma_ch2_overrun_en = mask_ff[6][`IEB_B_DMA_OVERRUN]; // RL15
   assign dma_ch2_dest_count_en = mask_ff[6][`IEB_B_DMA_DEST]; // RL15
   assign dma_ch2_src_count_en = mask_ff[6][`IEB_B_DMA_SRC]; // RL15
   assign osc_generator_irq_en = mask_ff[6][`IEB_B_OSC_GEN]; // RL16
   assign waveform_gen_irq_en = mask_ff[6][`IEB_B_WAVE_GEN]; // RL16
   assign ext_pin1_irq_en = mask_ff[6][`IEB_B_EXT_PIN1]; // RL16

   // Register seven
   assign pwm_unit3_param_en = mask_ff[7][`IEB_B_PWM_PARAM]; // RL17
   assign pwm_unit3_period_en = mask_ff[7][`IEB_B_PWM_PERIOD]; // RL17
   assign logic_cell3_irq_en = mask_ff[7][`IEB_B_CELL3]; // RL17
   assign i2c_port1_error_en = mask_ff[7][`IEB_B_I2C_ERR]; // RL18
   assign i2c_port1_irq_en = mask_ff[7][`IEB_B_SER_GEN]; // RL18
   assign i2c_port1_tx_en = mask_ff[7][`IEB_B_SER_TX]; // RL18
   assign i2c_port1_rx_en = mask_ff[7][`IEB_B_SER_RX]; // RL18

   // Gate vectors; positions left unset stay zero, so absent bits
   // can never pass a flag through
   always_comb begin
      for (int r = 1; r <= 7; r++) begin
         gate_a[r] = 8'h00; // RL22
      end
      // Register one
      gate_a[1][`IEB_B_ADC_DONE] = adc_done_irq_en;
      gate_a[1][`IEB_B_ZERO_CROSS] = zero_cross_irq_en;
      gate_a[1][`IEB_B_EXT_PIN0] = ext_pin0_irq_en;

      // Register two
      gate_a[2][`IEB_B_DMA_ABORT] = dma_ch1_abort_en;
      gate_a[2][`IEB_B_DMA_OVERRUN] = dma_ch1_overrun_en;
      gate_a[2][`IEB_B_DMA_DEST] = dma_ch1_dest_count_en;
      gate_a[2][`IEB_B_DMA_SRC] = dma_ch1_src_count_en;
      gate_a[2][`IEB_B_ADC_THRESH] = adc_threshold_irq_en;

      // Register three
      gate_a[3][`IEB_B_TMR0] = timer_zero_irq_en;
      gate_a[3][`IEB_B_CAPCOMP1] = capcomp_unit1_irq_en;
      gate_a[3][`IEB_B_TMR1_GATE] = timer_one_gate_irq_en;
      gate_a[3][`IEB_B_TMR1] = timer_one_irq_en;
      gate_a[3][`IEB_B_TMR2] = timer_two_irq_en;
      gate_a[3][`IEB_B_SER_GEN] = spi_port1_irq_en;
      gate_a[3][`IEB_B_SER_TX] = spi_port1_tx_en;
      gate_a[3][`IEB_B_SER_RX] = spi_port1_rx_en;

      // Register four
      gate_a[4][`IEB_B_PWM_PARAM] = pwm_unit1_param_en;
      gate_a[4][`IEB_B_PWM_PERIOD] = pwm_unit1_period_en;
      gate_a[4][`IEB_B_TMR3_GATE] = timer_three_gate_irq_en;
      gate_a[4][`IEB_B_TMR3] = timer_three_irq_en;
      gate_a[4][`IEB_B_UART_GEN] = uart_port1_irq_en;
      gate_a[4][`IEB_B_UART_FRAME] = uart_port1_framing_en;
      gate_a[4][`IEB_B_SER_TX] = uart_port1_tx_en;
      gate_a[4][`IEB_B_SER_RX] = uart_port1_rx_en;

      // Register five
      gate_a[5][`IEB_B_PWM_PARAM] = pwm_unit2_param_en;
      gate_a[5][`IEB_B_PWM_PERIOD] = pwm_unit2_period_en;
      gate_a[5][`IEB_B_CELL2] = logic_cell2_irq_en;
      gate_a[5][`IEB_B_CMP2] = comparator2_irq_en;
      gate_a[5][`IEB_B_SER_GEN] = spi_port2_irq_en;
      gate_a[5][`IEB_B_SER_TX] = spi_port2_tx_en;
      gate_a[5][`IEB_B_SER_RX] = spi_port2_rx_en;

      // Register six
      gate_a[6][`IEB_B_DMA_ABORT] = dma_ch2_abort_en;
      gate_a[6][`IEB_B_DMA_OVERRUN] = dma_ch2_overrun_en;
      gate_a[6][`IEB_B_DMA_DEST] = dma_ch2_dest_count_en;
      gate_a[6][`IEB_B_DMA_SRC] = dma_ch2_src_count_en;
      gate_a[6][`IEB_B_OSC_GEN] = osc_generator_irq_en;
      gate_a[6][`IEB_B_WAVE_GEN] = waveform_gen_irq_en;
      gate_a[6][`IEB_B_EXT_PIN1] = ext_pin1_irq_en;

      // Register seven
      gate_a[7][`IEB_B_PWM_PARAM] = pwm_unit3_param_en;
      gate_a[7][`IEB_B_PWM_PERIOD] = pwm_unit3_period_en;
      gate_a[7][`IEB_B_CELL3] = logic_cell3_irq_en;
      gate_a[7][`IEB_B_I2C_ERR] = i2c_port1_error_en;
      gate_a[7][`IEB_B_SER_GEN] = i2c_port1_irq_en;
      gate_a[7][`IEB_B_SER_TX] = i2c_port1_tx_en;
      gate_a[7][`IEB_B_SER_RX] = i2c_port1_rx_en;
   end

endmodule

// *** verilog/ieb_cfg.svh ***
// Offsets, bit positions and reset values of the enable bank
`ifndef IEB_CFG_SVH
`define IEB_CFG_SVH
// Register indices; byte address is four times the index
`define IEB_IDX_R1 11'h4a9
`define IEB_IDX_R2 11'h4aa
`define IEB_IDX_R3 11'h4ab
`define IEB_IDX_R4 11'h4ac
`define IEB_IDX_R5 11'h4ad
`define IEB_IDX_R6 11'h4ae
`define IEB_IDX_R7 11'h4af
`define IEB_IDX_BASE 11'h4a8
// Implemented bits per register
`define IEB_IMPL_R1 8'h07
`define IEB_IMPL_R2 8'hf1
`define IEB_IMPL_R3 8'hff
`define IEB_IMPL_R4 8'hff
`define IEB_IMPL_R5 8'hf7
`define IEB_IMPL_R6 8'hfd
`define IEB_IMPL_R7 8'hef
`define IEB_RST_VAL 8'h00
// Bit positions, one group per register
`define IEB_B_ADC_DONE 3'h2
`define IEB_B_ZERO_CROSS 3'h1
`define IEB_B_EXT_PIN0 3'h0
`define IEB_B_DMA_ABORT 3'h7
`define IEB_B_DMA_OVERRUN 3'h6
`define IEB_B_DMA_DEST 3'h5
`define IEB_B_DMA_SRC 3'h4
`define IEB_B_ADC_THRESH 3'h0
`define IEB_B_TMR0 3'h7
`define IEB_B_CAPCOMP1 3'h6
`define IEB_B_TMR1_GATE 3'h5
`define IEB_B_TMR1 3'h4
`define IEB_B_TMR2 3'h3
`define IEB_B_SER_GEN 3'h2
`define IEB_B_SER_TX 3'h1
`define IEB_B_SER_RX 3'h0
`define IEB_B_PWM_PARAM 3'h7
`define IEB_B_PWM_PERIOD 3'h6
`define IEB_B_TMR3_GATE 3'h5
`define IEB_B_TMR3 3'h4
`define IEB_B_UART_GEN 3'h3
`define IEB_B_UART_FRAME 3'h2
`define IEB_B_CELL2 3'h5
`define IEB_B_CMP2 3'h4
`define IEB_B_OSC_GEN 3'h3
`define IEB_B_WAVE_GEN 3'h2
`define IEB_B_EXT_PIN1 3'h0
`define IEB_B_CELL3 3'h5
`define IEB_B_I2C_ERR 3'h3
// Bus answers
`define IEB_RESP_OK 2'h0
`define IEB_RESP_ERR 2'h2
`endif

// *** verilog/ieb_pkg.sv ***
// Types shared by the interrupt enable bank
package ieb_pkg;
   typedef logic [7:0] ieb_byte_t;
   typedef enum logic [1:0] {
      IEB_ST_IDLE = 2'b01,
      IEB_ST_ANS = 2'b10
   } ieb_bus_st_t;
endpackage
